// ---- src/hbp_pkg.sv ----
/*
 constants, types and field positions shared by both ends of the parallel
 host port. assumes a single 10 MHz reference clock on each end.
*/
// Operation
// - static high style pin: data-strobe, demultiplexed
// - static low style pin: read/write strobes, demultiplexed
// - style pin falling edge selects multiplexed mode
// - multiplexed: latch address on latch-enable fall
// - host ties address pins to data lines
// - 8-bit part on 16-bit bus: shifted address
// - low shared pin is address bit zero
// - 16-bit strobe style: low lane enable
// - high lane enable; ignored in 8-bit
// - 16-bit data-strobe: per-lane strobes
// - 8-bit data-strobe: single strobe times transfer
// - direction line stable while strobe active
// - read strobe: device drives data
// - chip select high: ignore, bus undriven
// - write strobe: host holds valid data
// - acknowledge until strobe or select inactive
// - width select low 8-bit, high 16-bit
package hbp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   // control pin vector positions
   localparam int CTL_CS = 7;
   localparam int CTL_RD = 6;
   localparam int CTL_WR = 5;
   localparam int CTL_RW = 4;
   localparam int CTL_SH0 = 3;
   localparam int CTL_SH1 = 2;
   localparam int CTL_WIDTH = 1;
   localparam int CTL_BSS = 0;
   // strobes, select, shared pins idle high; width and style low
   localparam logic [7:0] CTL_SYNC_RST = 8'hfc;
   localparam logic [15:0] BUS_PULLUP = 16'hffff;
   localparam logic [7:0] LANE_ZERO = 8'h00;
   localparam logic [1:0] BE_LOW = 2'h1;
   // host phase setup time
   localparam int CLK_NS = 100;
   localparam int SETUP_NS = 300;
   localparam logic [2:0] SETUP_CYC =
      3'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_FETCH = 2'b01,
      DEV_HOLD = 2'b10
   } hbp_dev_state_t;
   typedef enum logic [2:0] {
      HST_IDLE = 3'b000,
      HST_ADDR = 3'b001,
      HST_LATCH = 3'b010,
      HST_STROBE = 3'b011,
      HST_RELEASE = 3'b100
   } hbp_host_state_t;
   typedef enum logic [1:0] {
      STYLE_STROBE = 2'b00,
      STYLE_DSTROBE = 2'b01,
      STYLE_MUX = 2'b10
   } hbp_style_t;
endpackage

// ---- src/hbp_bus_if.sv ----
/*
 pin bundle between host and device ends. resolves the shared data bus
 and the acknowledge line from their output enables, with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
interface hbp_bus_if;
   logic csN;
   logic rdN;
   logic wrN;
   logic rwN;
   logic addrBitZero;
   logic singleDataStrobeN;
   logic busStyleSelect;
   logic widthSelect;
   logic [7:1] addrHigh;
   logic [15:0] hostData;
   logic hostDataOeN;
   logic [15:0] devData;
   logic devDataOeN;
   logic transferAcknowledgeN;
   logic ackOeN;
   logic [15:0] dataBus;
   logic ackLine;
   // enables are low while driving; undriven lines float high
   assign dataBus = !devDataOeN ? devData :
                    (!hostDataOeN ? hostData : hbp_pkg::BUS_PULLUP);
   assign ackLine = !ackOeN ? transferAcknowledgeN : 1'b1;
   modport device (
      input csN, rdN, wrN, rwN, addrBitZero, singleDataStrobeN,
      input busStyleSelect, widthSelect, addrHigh, dataBus,
      output devData, devDataOeN, transferAcknowledgeN, ackOeN
   );
   modport host (
      output csN, rdN, wrN, rwN, addrBitZero, singleDataStrobeN,
      output busStyleSelect, widthSelect, addrHigh, hostData, hostDataOeN,
      input dataBus, ackLine
   );
endinterface
`default_nettype wire

// ---- src/hbp_device.sv ----
/*
 device end of the parallel host port: decodes the three bus styles and
 turns each strobe assertion into one register read or write pulse.
 assumes the register side answers a read in the same cycle that regRd is high.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_device (
   input wire logic ref_clk,
   input wire logic arst_n,
   hbp_bus_if.device bus,
   output logic regWr,
   output logic regRd,
   output logic [hbp_pkg::ADDR_W-1:0] regAddr,
   output logic [hbp_pkg::DATA_W-1:0] regWrData,
   output logic [1:0] regByteEn,
   input wire logic [hbp_pkg::DATA_W-1:0] regRdData,
   output logic muxMode
);
   import hbp_pkg::*;

   logic [7:0] ctlS1;
   logic [7:0] ctlS2;
   logic [7:1] addrS1;
   logic [7:1] addrS2;
   logic [15:0] dataS1;
   logic [15:0] dataS2;
   logic bssPrev;
   logic [7:0] latchAddr;
   logic next_muxMode;
   logic [7:0] next_latchAddr;
   hbp_dev_state_t state;
   hbp_dev_state_t next_state;
   logic next_regWr;
   logic next_regRd;
   logic [7:0] next_regAddr;
   logic [15:0] next_regWrData;
   logic [1:0] next_regByteEn;
   logic [15:0] rdBuf;
   logic [15:0] next_rdBuf;
   logic rdAccess;
   logic next_rdAccess;
   logic ackN;
   logic next_ackN;
   logic ackOeN;
   logic next_ackOeN;
   logic dataOeN;
   logic next_dataOeN;
   logic dsStyle;
   logic wide;
   logic strobeOn;
   logic active;
   logic isRead;
   logic [1:0] accBe;
   logic [7:0] accAddr;
   logic [7:0] baseAddr;
   logic [15:0] accWrData;
   logic latchFall;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctlS1 <= CTL_SYNC_RST;
         ctlS2 <= CTL_SYNC_RST;
         addrS1 <= '0;
         addrS2 <= '0;
         dataS1 <= '0;
         dataS2 <= '0;
      end else begin
         ctlS1 <= {bus.csN, bus.rdN, bus.wrN, bus.rwN, bus.addrBitZero,
                   bus.singleDataStrobeN, bus.widthSelect,
                   bus.busStyleSelect};
         ctlS2 <= ctlS1;
         addrS1 <= bus.addrHigh;
         addrS2 <= addrS1;
         dataS1 <= bus.dataBus;
         dataS2 <= dataS1;
      end
   end

   // reset value low so a pin held high at reset is no falling edge
   assign latchFall = bssPrev & !ctlS2[CTL_BSS];

   always_comb begin
      next_muxMode = muxMode;
      next_latchAddr = latchAddr;
      if (latchFall) begin
         next_muxMode = 1'b1;
         next_latchAddr = dataS2[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bssPrev <= 1'b0;
         muxMode <= 1'b0;
         latchAddr <= '0;
      end else begin
         bssPrev <= ctlS2[CTL_BSS];
         muxMode <= next_muxMode;
         latchAddr <= next_latchAddr;
      end
   end

   always_comb begin
      dsStyle = ctlS2[CTL_BSS] & !muxMode;
      wide = ctlS2[CTL_WIDTH];
      if (dsStyle) begin
         strobeOn = wide ? (!ctlS2[CTL_SH0] | !ctlS2[CTL_SH1])
                         : !ctlS2[CTL_SH1];
         isRead = ctlS2[CTL_RW];
         accBe = wide ? {!ctlS2[CTL_SH0], !ctlS2[CTL_SH1]} : BE_LOW;
      end else begin
         strobeOn = !ctlS2[CTL_RD] | !ctlS2[CTL_WR];
         isRead = !ctlS2[CTL_RD];
         // lane enables, high one unused when narrow
         accBe = wide ? {!ctlS2[CTL_SH1], !ctlS2[CTL_SH0]} : BE_LOW;
      end
      active = !ctlS2[CTL_CS] & strobeOn;
      // shared pin is address bit zero
      baseAddr = muxMode ? latchAddr : {addrS2, ctlS2[CTL_SH0]};
      // word lanes address the even byte
      accAddr = wide ? {baseAddr[7:1], 1'b0} : baseAddr;
      accWrData = wide ? dataS2 : {LANE_ZERO, dataS2[7:0]};
   end

   always_comb begin
      next_state = state;
      next_regWr = 1'b0;
      next_regRd = 1'b0;
      next_regAddr = regAddr;
      next_regWrData = regWrData;
      next_regByteEn = regByteEn;
      next_rdBuf = rdBuf;
      next_rdAccess = rdAccess;
      next_ackN = 1'b1;
      next_ackOeN = 1'b1;
      next_dataOeN = 1'b1;
      case (state)
         DEV_IDLE: begin
            if (active) begin
               next_regAddr = accAddr;
               next_regByteEn = accBe;
               next_regWrData = accWrData;
               next_rdAccess = isRead;
               if (isRead) begin
                  next_regRd = 1'b1;
                  next_state = DEV_FETCH;
               end else begin
                  next_regWr = 1'b1;
                  next_state = DEV_HOLD;
                  next_ackN = 1'b0;
                  next_ackOeN = 1'b0;
               end
            end
         end
         DEV_FETCH: begin
            next_rdBuf = wide ? regRdData : {LANE_ZERO, regRdData[7:0]};
            if (active) begin
               next_state = DEV_HOLD;
               next_ackN = 1'b0;
               next_ackOeN = 1'b0;
               next_dataOeN = 1'b0;
            end else begin
               next_state = DEV_IDLE;
            end
         end
         DEV_HOLD: begin
            // hold ack while strobe and select
            if (active) begin
               next_ackN = 1'b0;
               next_ackOeN = 1'b0;
               next_dataOeN = !rdAccess;
            end else begin
               next_state = DEV_IDLE;
            end
         end
         default: begin
            next_state = DEV_IDLE;
         end
      endcase
   end

   // pins start released; nothing is driven during reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= DEV_IDLE;
         regWr <= 1'b0;
         regRd <= 1'b0;
         regAddr <= '0;
         regWrData <= '0;
         regByteEn <= '0;
         rdBuf <= '0;
         rdAccess <= 1'b0;
         ackN <= 1'b1;
         ackOeN <= 1'b1;
         dataOeN <= 1'b1;
      end else begin
         state <= next_state;
         regWr <= next_regWr;
         regRd <= next_regRd;
         regAddr <= next_regAddr;
         regWrData <= next_regWrData;
         regByteEn <= next_regByteEn;
         rdBuf <= next_rdBuf;
         rdAccess <= next_rdAccess;
         ackN <= next_ackN;
         ackOeN <= next_ackOeN;
         dataOeN <= next_dataOeN;
      end
   end

   assign bus.devData = rdBuf;
   assign bus.devDataOeN = dataOeN;
   assign bus.transferAcknowledgeN = ackN;
   assign bus.ackOeN = ackOeN;
endmodule
`default_nettype wire

// ---- src/hbp_host.sv ----
/*
 host end of the parallel port: runs one register access per command in
 the selected bus style. assumes style and width stay fixed once used.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
   input wire logic ref_clk,
   input wire logic arst_n,
   hbp_bus_if.host bus,
   input wire hbp_pkg::hbp_style_t hostStyle,
   input wire logic hostWide,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [hbp_pkg::ADDR_W-1:0] cmdAddr,
   input wire logic [hbp_pkg::DATA_W-1:0] cmdWrData,
   input wire logic [1:0] cmdByteEn,
   output logic cmdReady,
   output logic respDone,
   output logic [hbp_pkg::DATA_W-1:0] respRdData
);
   import hbp_pkg::*;

   logic ackS1;
   logic ackS2;
   logic [15:0] dataS1;
   logic [15:0] dataS2;
   hbp_host_state_t state;
   hbp_host_state_t next_state;
   hbp_style_t cStyle;
   hbp_style_t next_cStyle;
   logic cWide, next_cWide, cWr, next_cWr;
   logic [7:0] cAddr, next_cAddr;
   logic [15:0] cData, next_cData, next_respRdData;
   logic [1:0] cBe, next_cBe;
   logic [2:0] cnt, next_cnt;
   logic next_respDone;
   logic [7:0] pins, next_pins;
   logic [15:0] dOut, next_dOut;
   logic dOeN, next_dOeN;
   logic ds, mux, busy, strobing, muxPhase;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ackS1 <= 1'b1;
         ackS2 <= 1'b1;
         dataS1 <= '0;
         dataS2 <= '0;
      end else begin
         ackS1 <= bus.ackLine;
         ackS2 <= ackS1;
         dataS1 <= bus.dataBus;
         dataS2 <= dataS1;
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cStyle = cStyle;
      next_cWide = cWide;
      next_cWr = cWr;
      next_cAddr = cAddr;
      next_cData = cData;
      next_cBe = cBe;
      next_respDone = 1'b0;
      next_respRdData = respRdData;
      case (state)
         HST_IDLE: begin
            next_cStyle = hostStyle;
            next_cWide = hostWide;
            if (cmdValid) begin
               next_cWr = cmdWrite;
               next_cAddr = cmdAddr;
               next_cData = cmdWrData;
               next_cBe = hostWide ? cmdByteEn : BE_LOW;
               next_cnt = SETUP_CYC;
               next_state = HST_ADDR;
            end
         end
         HST_ADDR: begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h0) begin
               next_cnt = SETUP_CYC;
               next_state = (cStyle == STYLE_MUX) ? HST_LATCH : HST_STROBE;
            end
         end
         HST_LATCH: begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h0) begin
               next_state = HST_STROBE;
            end
         end
         HST_STROBE: begin
            if (!ackS2) begin
               next_respRdData = cWide ? dataS2 : {LANE_ZERO, dataS2[7:0]};
               next_state = HST_RELEASE;
            end
         end
         HST_RELEASE: begin
            if (ackS2) begin
               next_respDone = 1'b1;
               next_state = HST_IDLE;
            end
         end
         default: begin
            next_state = HST_IDLE;
         end
      endcase
   end

   always_comb begin
      ds = next_cStyle == STYLE_DSTROBE;
      mux = next_cStyle == STYLE_MUX;
      busy = next_state != HST_IDLE && next_state != HST_RELEASE;
      strobing = next_state == HST_STROBE;
      muxPhase = mux && (next_state == HST_ADDR || next_state == HST_LATCH);
      next_pins[CTL_CS] = !busy;
      next_pins[CTL_RD] = !(strobing & !ds & !next_cWr);
      next_pins[CTL_WR] = !(strobing & !ds & next_cWr);
      next_pins[CTL_RW] = ds ? !next_cWr : 1'b1;
      if (next_cWide) begin
         // lane enables only with the strobe: a device not yet in mux
         // mode reads them as data strobes while the style pin is high
         next_pins[CTL_SH0] = ds ? !(strobing & next_cBe[1])
                                 : !(strobing & next_cBe[0]);
         next_pins[CTL_SH1] = ds ? !(strobing & next_cBe[0])
                                 : !(strobing & next_cBe[1]);
      end else begin
         next_pins[CTL_SH0] = next_cAddr[0];
         next_pins[CTL_SH1] = ds ? !strobing : 1'b1;
      end
      next_pins[CTL_WIDTH] = next_cWide;
      // address on data lines, then latch fall
      next_pins[CTL_BSS] = ds | (mux & next_state == HST_ADDR);
      // byte address on the low lanes
      next_dOut = muxPhase ? {LANE_ZERO, next_cAddr} : next_cData;
      next_dOeN = !(muxPhase | (next_cWr & busy));
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= HST_IDLE;
         cnt <= '0;
         cStyle <= STYLE_STROBE;
         cWide <= 1'b0;
         cWr <= 1'b0;
         cAddr <= '0;
         cData <= '0;
         cBe <= '0;
         respDone <= 1'b0;
         respRdData <= '0;
         cmdReady <= 1'b0;
         pins <= CTL_SYNC_RST;
         dOut <= '0;
         dOeN <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cStyle <= next_cStyle;
         cWide <= next_cWide;
         cWr <= next_cWr;
         cAddr <= next_cAddr;
         cData <= next_cData;
         cBe <= next_cBe;
         respDone <= next_respDone;
         respRdData <= next_respRdData;
         cmdReady <= next_state == HST_IDLE;
         pins <= next_pins;
         dOut <= next_dOut;
         dOeN <= next_dOeN;
      end
   end

   assign bus.csN = pins[CTL_CS];
   assign bus.rdN = pins[CTL_RD];
   assign bus.wrN = pins[CTL_WR];
   assign bus.rwN = pins[CTL_RW];
   assign bus.addrBitZero = pins[CTL_SH0];
   assign bus.singleDataStrobeN = pins[CTL_SH1];
   assign bus.widthSelect = pins[CTL_WIDTH];
   assign bus.busStyleSelect = pins[CTL_BSS];
   assign bus.addrHigh = cAddr[7:1];
   assign bus.hostData = dOut;
   assign bus.hostDataOeN = dOeN;
endmodule
`default_nettype wire

// ---- verification/hbp_chk.sv ----
/*
 pin-level checks on the host port bundle between host and device ends.
 expects the bench to pass the bundle signals, clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_chk (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic csN,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic rwN,
   input wire logic singleDataStrobeN,
   input wire logic busStyleSelect,
   input wire logic hostDataOeN,
   input wire logic devDataOeN,
   input wire logic transferAcknowledgeN,
   input wire logic ackOeN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // sync stages delay release, so allow a few cycles
   property p_deselQuiet;
      csN[*5] |-> devDataOeN && ackOeN;
   endproperty
   a_deselQuiet: assert property (p_deselQuiet)
      else $error("bus driven while deselected");
   property p_releaseBound;
      $rose(csN) |-> ##[0:4] (ackOeN && devDataOeN);
   endproperty
   a_releaseBound: assert property (p_releaseBound)
      else $error("ack or data not released");
   property p_driveOnRead;
      $fell(devDataOeN) |-> !csN && wrN && rwN;
   endproperty
   a_driveOnRead: assert property (p_driveOnRead)
      else $error("data driven outside a read");
   property p_ackWithData;
      $fell(devDataOeN) |-> !ackOeN && !transferAcknowledgeN;
   endproperty
   a_ackWithData: assert property (p_ackWithData)
      else $error("read data without ack");
   property p_ackHeld;
      !ackOeN && !csN && !wrN |=> !ackOeN && !transferAcknowledgeN;
   endproperty
   a_ackHeld: assert property (p_ackHeld)
      else $error("ack dropped while strobe active");
   property p_writeAnswer;
      $fell(wrN) && !csN |-> ##[1:5] !ackOeN;
   endproperty
   a_writeAnswer: assert property (p_writeAnswer)
      else $error("write strobe not acknowledged");
   property p_readAnswer;
      $fell(rdN) && !csN |-> ##[1:6] !devDataOeN;
   endproperty
   a_readAnswer: assert property (p_readAnswer)
      else $error("read strobe not answered");
   property p_dirStable;
      !singleDataStrobeN && $past(!singleDataStrobeN) |-> $stable(rwN);
   endproperty
   a_dirStable: assert property (p_dirStable)
      else $error("direction moved during strobe");
   property p_writeData;
      !wrN |-> !hostDataOeN;
   endproperty
   a_writeData: assert property (p_writeData)
      else $error("write strobe without data");
   property p_latchAddr;
      $fell(busStyleSelect) |-> $past(!hostDataOeN);
   endproperty
   a_latchAddr: assert property (p_latchAddr)
      else $error("no address before latch fall");
   property p_noClash;
      !devDataOeN |-> hostDataOeN;
   endproperty
   a_noClash: assert property (p_noClash)
      else $error("both ends drive data");
endmodule
`default_nettype wire

// ---- verification/hbp_tb.sv ----
/*
 bench joining host and device ends through one pin bundle.
 drives host commands and device read data; checks both user sides.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_tb;
   import hbp_pkg::*;
   logic ref_clk;
   logic arst_n;
   hbp_style_t hostStyle;
   logic hostWide;
   logic cmdValid;
   logic cmdWrite;
   logic [7:0] cmdAddr;
   logic [15:0] cmdWrData;
   logic [1:0] cmdByteEn;
   logic cmdReady;
   logic respDone;
   logic [15:0] respRdData;
   logic regWr;
   logic regRd;
   logic [7:0] regAddr;
   logic [15:0] regWrData;
   logic [1:0] regByteEn;
   logic [15:0] regRdData;
   logic muxMode;
   logic [7:0] a;
   logic [15:0] d;
   logic [1:0] be;
   int badCount = 0;
   int checksDone = 0;
   int accCount = 0;
   integer seed = 61;
   hbp_bus_if bus ();
   hbp_host i_hbp_host (
      .ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
      .hostStyle(hostStyle), .hostWide(hostWide),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
      .cmdWrData(cmdWrData), .cmdByteEn(cmdByteEn),
      .cmdReady(cmdReady), .respDone(respDone), .respRdData(respRdData)
   );
   hbp_device i_hbp_device (
      .ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
      .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
      .regWrData(regWrData), .regByteEn(regByteEn),
      .regRdData(regRdData), .muxMode(muxMode)
   );
   hbp_chk i_hbp_chk (
      .ref_clk(ref_clk), .arst_n(arst_n), .csN(bus.csN),
      .rdN(bus.rdN), .wrN(bus.wrN), .rwN(bus.rwN),
      .singleDataStrobeN(bus.singleDataStrobeN),
      .busStyleSelect(bus.busStyleSelect),
      .hostDataOeN(bus.hostDataOeN), .devDataOeN(bus.devDataOeN),
      .transferAcknowledgeN(bus.transferAcknowledgeN),
      .ackOeN(bus.ackOeN)
   );
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (regWr === 1'b1 || regRd === 1'b1) begin
         accCount++;
      end
   end
   function automatic logic [7:0] expAddr(input logic [7:0] x);
      return hostWide ? {x[7:1], 1'b0} : x;
   endfunction
   function automatic logic [15:0] laneMask(input logic [1:0] b);
      return hostWide ? {{8{b[1]}}, {8{b[0]}}} : 16'h00ff;
   endfunction
   function automatic logic [1:0] expBe(input logic [1:0] b);
      return hostWide ? b : 2'h1;
   endfunction
   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic endSim();
      if (badCount == 0 && checksDone > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one host command; device read data mirrors the read value
   task automatic access(input logic wr, input logic [7:0] x,
         input logic [15:0] v, input logic [1:0] b);
      int n;
      int base;
      logic [15:0] m;
      m = laneMask(b);
      n = 0;
      @(negedge ref_clk);
      while (cmdReady !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      base = accCount;
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdWrite <= wr;
      cmdAddr <= x;
      cmdWrData <= v;
      cmdByteEn <= b;
      regRdData <= wr ? ~v : v;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      n = 0;
      @(negedge ref_clk);
      while (respDone !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      check("done", {15'h0, respDone}, 16'h0001);
      check("ready", {15'h0, cmdReady}, 16'h0001);
      check("accesses", 16'(accCount - base), 16'h0001);
      check("address", {8'h00, regAddr}, {8'h00, expAddr(x)});
      check("lanes", {14'h0, regByteEn}, {14'h0, expBe(b)});
      if (wr) begin
         check("write data", regWrData & m, v & m);
      end else begin
         check("read data", respRdData & m, v & m);
      end
   endtask
   initial begin
      arst_n = 1'b0;
      hostStyle = STYLE_STROBE;
      hostWide = 1'b0;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdAddr = 8'h00;
      cmdWrData = 16'h0000;
      cmdByteEn = 2'h1;
      regRdData = 16'h0000;
      // each style and width gets its own reset; mux mode sticks
      for (int s = 0; s < 3; s++) begin
         for (int w = 0; w < 2; w++) begin
            @(posedge ref_clk);
            arst_n <= 1'b0;
            hostStyle <= hbp_style_t'(s);
            hostWide <= w[0];
            repeat (8) @(posedge ref_clk);
            arst_n <= 1'b1;
            @(negedge ref_clk);
            check("mode at reset", {15'h0, muxMode}, 16'h0000);
            for (int i = 0; i < 8; i++) begin
               a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
               d = 16'($random(seed));
               be = (i == 0) ? 2'b10 : 2'($random(seed));
               if (be == 2'b00) begin
                  be = 2'b11;
               end
               access(1'b1, a, d, be);
               access(1'b0, a, ~d, be);
            end
            check("mux mode", {15'h0, muxMode}, {15'h0, s == 2});
         end
      end
      endSim();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      badCount++;
      endSim();
   end
endmodule
`default_nettype wire
